// [rtl/mmp_module.sv]
// module end: sideband pins, reset sequencing and 2-wire managed memory
//
// The APB register port was decided locally.
`include "mmp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mmp_module #(
   parameter int         RESET_MIN_CYC = `MMP_RESET_MIN_CYC,  // see R18
   parameter int         INIT_CYC      = `MMP_INIT_CYC,       // see R18
   parameter logic [7:0] ID_CODE       = 8'h5a  // arbitrary value
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // link to host
   mmp_if.module_end       lnk,
   // user side
   input  wire logic       fault_event,
   output var  logic       power_save_active,
   output var  logic       status_valid
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic [4:0] pin_raw;
   logic       scl_d;
   logic       sda_d;
   assign pin_raw = {lnk.scl, lnk.sda, lnk.bus_select_n, lnk.module_reset_n,
                     lnk.power_save_request};

   // reset values leave an undriven select deselected
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pin_meta <= `MMP_PIN_IDLE;  // see R3
         pin_sync <= `MMP_PIN_IDLE;  // see R4
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;  // see R19
         scl_d    <= pin_sync[4];
         sda_d    <= pin_sync[3];
      end

   wire logic scl_s    = pin_sync[4];
   wire logic sda_s    = pin_sync[3];
   wire logic selected = ~pin_sync[2];  // see R1
   wire logic rst_s    = pin_sync[1];
   wire logic scl_rise = scl_s & ~scl_d;
   wire logic scl_fall = ~scl_s & scl_d;
   wire logic start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire logic stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // reset filter and initialisation interval
   // ----------------------------------------------------------------
   logic [31:0] low_cnt;
   logic [31:0] init_cnt;
   wire logic   low_done  = (low_cnt == 32'(RESET_MIN_CYC));
   wire logic   not_ready = low_done | (init_cnt != 32'h0000_0000);
   wire logic   done_set  = ~low_done & (init_cnt == 32'h0000_0001);

   // short low glitches never reach the saturation count
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         low_cnt <= 32'h0000_0000;
      else if (rst_s)
         low_cnt <= 32'h0000_0000;
      else if (!low_done)
         low_cnt <= low_cnt + 32'h0000_0001;  // see R19

   // counting starts when the filtered reset line goes high again
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         init_cnt <= 32'(INIT_CYC);  // see R9
      else if (low_done)
         init_cnt <= 32'(INIT_CYC);  // see R6
      else if (init_cnt != 32'h0000_0000)
         init_cnt <= init_cnt - 32'h0000_0001;

   // ----------------------------------------------------------------
   // serial slave state
   // ----------------------------------------------------------------
   mmp_pkg::mmp_dev_state_t state;
   logic [7:0] shift;
   logic [3:0] bitcnt;
   logic [7:0] ptr;
   logic       is_read;
   logic       got_ptr;
   logic       nack;
   logic       sda_oe;

   logic [7:0] lower_mem [128];
   logic [7:0] upper_mem [512];
   logic       done_flag;
   logic       fault_flag;

   wire logic [7:0] page_sel  = lower_mem[7'(`MMP_PAGE_SEL_OFS)];
   wire logic [7:0] mask_byte = lower_mem[7'(`MMP_MASK_OFS)];
   wire logic [8:0] up_idx    = {page_sel[1:0], ptr[6:0]};  // see R16
   wire logic       byte_done = scl_fall & (bitcnt == 4'h8);
   wire logic       addr_hit  = (shift[7:1] == `MMP_DEV_ADDR >> 1);  // see R17
   wire logic       abort     = start_c | stop_c | ~selected | low_done;
   wire logic       rd_load   = ~abort & scl_fall &
                                (((state == mmp_pkg::DEV_ACK) & is_read) |
                                 ((state == mmp_pkg::DEV_RACK) & ~nack));
   wire logic       wr_ok     = ptr[7] ? (page_sel[1:0] != 2'h0)
                                       : (ptr >= `MMP_WR_LOW_OFS);
   wire logic       wr_en     = ~abort & (state == mmp_pkg::DEV_RECV) &
                                byte_done & got_ptr & wr_ok;
   wire logic       clr_stat  = rd_load & (ptr == `MMP_STATUS_OFS);
   wire logic       clr_flags = rd_load & (ptr == `MMP_FLAG_OFS);
   wire logic [7:0] stat_byte = 8'(not_ready) << `MMP_NRDY_BIT;
   wire logic [7:0] flag_byte = (8'(done_flag) << `MMP_DONE_BIT) |
                                (8'(fault_flag) << `MMP_FAULT_BIT);
   wire logic [7:0] rd_byte   =
      ptr[7]                   ? upper_mem[up_idx] :
      (ptr == `MMP_ID_OFS)     ? ID_CODE :
      (ptr == `MMP_STATUS_OFS) ? stat_byte :
      (ptr == `MMP_FLAG_OFS)   ? flag_byte : lower_mem[ptr[6:0]];  // see R15

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state   <= mmp_pkg::DEV_IDLE;
         shift   <= 8'h00;
         bitcnt  <= 4'h0;
         ptr     <= 8'h00;
         is_read <= 1'b0;
         got_ptr <= 1'b0;
         nack    <= 1'b0;
         sda_oe  <= 1'b0;
      end
      else if (abort)
      begin
         // a deselected module drops off the bus at once
         state  <= (start_c & selected & ~low_done) ? mmp_pkg::DEV_ADDR
                                                    : mmp_pkg::DEV_IDLE;  // see R2
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else
         unique case (state)
            mmp_pkg::DEV_IDLE: ;
            mmp_pkg::DEV_ADDR, mmp_pkg::DEV_RECV:
               if (scl_rise)
               begin
                  shift  <= {shift[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end
               else if (byte_done & (state == mmp_pkg::DEV_ADDR))
               begin
                  state   <= addr_hit ? mmp_pkg::DEV_ACK : mmp_pkg::DEV_IDLE;
                  sda_oe  <= addr_hit;  // see R1
                  is_read <= shift[0];
                  got_ptr <= got_ptr & shift[0];
               end
               else if (byte_done)
               begin
                  state   <= mmp_pkg::DEV_ACK;
                  sda_oe  <= 1'b1;
                  got_ptr <= 1'b1;
                  ptr     <= got_ptr ? ptr + 8'h01 : shift;
               end
            mmp_pkg::DEV_ACK:
               if (scl_fall)
               begin
                  state  <= is_read ? mmp_pkg::DEV_SEND : mmp_pkg::DEV_RECV;
                  bitcnt <= 4'h0;
                  shift  <= rd_byte;
                  sda_oe <= is_read & ~rd_byte[7];
                  ptr    <= is_read ? ptr + 8'h01 : ptr;
               end
            mmp_pkg::DEV_SEND:
               if (scl_rise)
                  bitcnt <= bitcnt + 4'h1;
               else if (byte_done)
               begin
                  state  <= mmp_pkg::DEV_RACK;
                  sda_oe <= 1'b0;
               end
               else if (scl_fall)
               begin
                  shift  <= {shift[6:0], 1'b0};
                  sda_oe <= ~shift[6];
               end
            mmp_pkg::DEV_RACK:
               if (scl_rise)
                  nack <= sda_s;
               else if (scl_fall)
               begin
                  // a master nack ends the read burst
                  state  <= nack ? mmp_pkg::DEV_IDLE : mmp_pkg::DEV_SEND;
                  bitcnt <= 4'h0;
                  shift  <= rd_byte;
                  sda_oe <= ~nack & ~rd_byte[7];
                  ptr    <= nack ? ptr : ptr + 8'h01;
               end
         endcase

   // ----------------------------------------------------------------
   // managed memory
   // ----------------------------------------------------------------
   // upper pages share one array; page 0 stays read only
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         for (int i = 0; i < 128; i++)
            lower_mem[i] <= 8'h00;
         for (int i = 0; i < 512; i++)
            upper_mem[i] <= 8'h00;
      end
      else if (low_done)
      begin
         for (int i = 0; i < 128; i++)
            lower_mem[i] <= 8'h00;  // see R5
         for (int i = 0; i < 512; i++)
            upper_mem[i] <= 8'h00;
         lower_mem[7'(`MMP_PAGE_SEL_OFS)] <= `MMP_PAGE_SEL_RST;
      end
      else if (wr_en & ptr[7])
         upper_mem[up_idx] <= shift;
      else if (wr_en)
         lower_mem[ptr[6:0]] <= shift;

   // ----------------------------------------------------------------
   // flags and sideband outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         done_flag         <= 1'b0;
         fault_flag        <= 1'b0;
         lnk.mod_att_oe    <= 1'b0;
         lnk.mod_att_o     <= 1'b0;
         lnk.mod_sda_o     <= 1'b0;
         lnk.mod_sda_oe    <= 1'b0;
         lnk.mod_ins_oe    <= 1'b1;
         power_save_active <= 1'b0;
         status_valid      <= 1'b0;
      end
      else
      begin
         // a new event wins over the read that clears it
         done_flag      <= done_set | (done_flag & ~clr_stat & ~low_done);  // see R8
         fault_flag     <= fault_event | (fault_flag & ~clr_flags & ~low_done);
         lnk.mod_att_oe <= done_flag |
                           (fault_flag & ~mask_byte[`MMP_FAULT_BIT]);  // see R12
         lnk.mod_att_o  <= 1'b0;  // see R13
         lnk.mod_sda_o  <= 1'b0;
         lnk.mod_sda_oe <= sda_oe;
         lnk.mod_ins_oe <= 1'b1;  // see R11
         power_save_active <= pin_sync[0];  // see R10
         status_valid      <= ~not_ready;
      end
endmodule  // mmp_module
`default_nettype wire

// [common/mmp_consts.svh]
// shared constants for the module end and the host end of the management link
`ifndef MMP_CONSTS_SVH
`define MMP_CONSTS_SVH
// Operation
// R1 - select low: module answers serial commands
// R2 - select high: module ignores all bus traffic
// R3 - select line pulled up inside module
// R4 - reset line pulled up inside module
// R5 - long reset low restores all writable defaults
// R6 - initialisation starts at reset rising edge
// R7 - host ignores status until completion flag
// R8 - end of init: attention, not-ready cleared
// R9 - power-up raises same completion attention
// R10 - power save input enters low-power state
// R11 - presence output low while module seated
// R12 - attention low flags fault or critical status
// R13 - attention only pulls low, host pulls up
// R14 - host reads flag byte after attention
// R15 - lower page 128 bytes always addressable
// R16 - page select byte maps upper page
// R17 - fixed bus address used for all accesses
// R18 - reset width and init time are parameters
// R19 - reset input synchronised and width filtered

// ----------------------------------------------------------------
// serial memory map
// ----------------------------------------------------------------
`define MMP_DEV_ADDR      8'ha0
`define MMP_ID_OFS        8'h00
`define MMP_STATUS_OFS    8'h02
`define MMP_FLAG_OFS      8'h03
`define MMP_MASK_OFS      8'h64
`define MMP_WR_LOW_OFS    8'h56
`define MMP_PAGE_SEL_OFS  8'h7f
`define MMP_PAGE_SEL_RST  8'h00
`define MMP_NRDY_BIT      0
`define MMP_DONE_BIT      0
`define MMP_FAULT_BIT     1
`define MMP_PIN_IDLE      5'h1e

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MMP_CLK_KHZ       40000
`define MMP_RESET_MIN_NS  10000
`define MMP_RESET_MIN_CYC ((`MMP_RESET_MIN_NS * `MMP_CLK_KHZ + 999999) / 1000000)
`define MMP_INIT_US       2000
`define MMP_INIT_CYC      (`MMP_INIT_US * `MMP_CLK_KHZ / 1000)
`define MMP_BIT_NS        10000
`define MMP_QUARTER_CYC   (`MMP_BIT_NS * `MMP_CLK_KHZ / 4000000)

// ----------------------------------------------------------------
// host register map
// ----------------------------------------------------------------
`define MMP_CTRL_OFS      8'h00
`define MMP_CMD_OFS       8'h04
`define MMP_STAT_OFS      8'h08
`define MMP_CTRL_SEL      0
`define MMP_CTRL_RST      1
`define MMP_CTRL_LP       2
`define MMP_CMD_RD        16
`endif

// [common/mmp_pkg.sv]
// state types for both ends of the management link
package mmp_pkg;
   typedef enum logic [2:0] {DEV_IDLE, DEV_ADDR, DEV_RECV, DEV_ACK, DEV_SEND,
                             DEV_RACK} mmp_dev_state_t;
   typedef enum logic [1:0] {HST_IDLE, HST_START, HST_BYTE,
                             HST_STOP} mmp_host_state_t;
endpackage

// [common/mmp_if.sv]
// sideband pins and 2-wire bus between host and module
`timescale 1ns/10ps
`default_nettype none
interface mmp_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic mod_sda_o;
   logic mod_sda_oe;
   logic host_sel_oe;
   logic host_rst_oe;
   logic power_save_request;
   logic mod_att_o;
   logic mod_att_oe;
   logic mod_ins_oe;
   // open-drain lines resolve to the pull-up when nobody drives
   wire logic sda = host_sda_oe ? host_sda_o : (mod_sda_oe ? mod_sda_o : 1'b1);
   wire logic bus_select_n   = ~host_sel_oe;  // see R3
   wire logic module_reset_n = ~host_rst_oe;  // see R4
   wire logic attention_n    = mod_att_oe ? mod_att_o : 1'b1;  // see R13
   wire logic inserted_n     = ~mod_ins_oe;   // see R11

   modport module_end (
      input  scl, sda, bus_select_n, module_reset_n, power_save_request,
      output mod_sda_o, mod_sda_oe, mod_att_o, mod_att_oe, mod_ins_oe
   );
   modport host_end (
      input  sda, attention_n, inserted_n,
      output scl, host_sda_o, host_sda_oe, host_sel_oe, host_rst_oe,
             power_save_request
   );
endinterface
`default_nettype wire

// [rtl/mmp_host.sv]
// host end: apb register slave driving the sideband pins and a 2-wire master
`include "mmp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mmp_host (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // link to module
   mmp_if.host_end          lnk
);
   localparam logic [15:0] QUARTER = 16'(`MMP_QUARTER_CYC);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] in_meta;
   logic [2:0] in_sync;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         in_meta <= 3'h7;
         in_sync <= 3'h7;
      end
      else
      begin
         in_meta <= {lnk.sda, lnk.attention_n, lnk.inserted_n};
         in_sync <= in_meta;
      end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   mmp_pkg::mmp_host_state_t state;
   logic [2:0]  ctrl;
   logic [7:0]  cmd_ofs;
   logic [7:0]  cmd_data;
   logic        cmd_rd;
   logic        nack;
   logic [7:0]  rdata;
   wire logic   busy    = (state != mmp_pkg::HST_IDLE);
   wire logic   setup   = psel & ~penable;
   wire logic   access  = psel & penable & pready;
   wire logic   hit_ctl = (paddr == `MMP_CTRL_OFS);
   wire logic   hit_cmd = (paddr == `MMP_CMD_OFS);
   wire logic   hit_st  = (paddr == `MMP_STAT_OFS);
   wire logic   go      = access & pwrite & hit_cmd & ~busy;
   wire logic [31:0] stat_word = {16'h0000, rdata, 4'h0, ~in_sync[0],
                                  ~in_sync[1], nack, busy};  // see R14

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrl    <= 3'h0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~(hit_ctl | hit_cmd | hit_st);
         prdata  <= ~setup ? prdata : hit_ctl ? {29'h0000_0000, ctrl} :
                    hit_st ? stat_word : 32'h0000_0000;
         if (access & pwrite & hit_ctl)
            ctrl <= pwdata[2:0];
      end

   // ----------------------------------------------------------------
   // bit timing and 2-wire master
   // ----------------------------------------------------------------
   logic [15:0] qcnt;
   logic [1:0]  phase;
   logic [2:0]  step;
   logic [3:0]  bitn;
   logic [8:0]  txsh;
   logic [8:0]  rxsh;
   wire logic   tick     = busy & (qcnt == QUARTER - 16'h0001);
   wire logic   last_rd  = cmd_rd & (step == 3'h3);
   wire logic   byte_end = (phase == 2'h3) & (bitn == 4'h8);
   // reads re-address after the offset byte with a repeated start
   wire logic [7:0] tx_byte = (step == 3'h0) ? `MMP_DEV_ADDR :
                              (step == 3'h1) ? cmd_ofs :
                              cmd_rd ? (`MMP_DEV_ADDR | 8'h01) : cmd_data;  // see R17

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         qcnt <= 16'h0000;
      else
         qcnt <= (tick | ~busy) ? 16'h0000 : qcnt + 16'h0001;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state    <= mmp_pkg::HST_IDLE;
         {cmd_ofs, cmd_data, cmd_rd, nack, rdata} <= 26'h000_0000;
         {phase, step, bitn, txsh, rxsh} <= 27'h000_0000;
         lnk.scl         <= 1'b1;
         lnk.host_sda_oe <= 1'b0;
      end
      else if (go)
      begin
         state    <= mmp_pkg::HST_START;
         cmd_ofs  <= pwdata[7:0];
         cmd_data <= pwdata[15:8];
         cmd_rd   <= pwdata[`MMP_CMD_RD];
         nack     <= 1'b0;
         phase    <= 2'h0;
         step     <= 3'h0;
      end
      else if (tick)
      begin
         phase <= phase + 2'h1;
         unique case (state)
            mmp_pkg::HST_IDLE: ;
            mmp_pkg::HST_START:
            begin
               lnk.host_sda_oe <= (phase >= 2'h2);
               lnk.scl         <= (phase == 2'h1) | (phase == 2'h2);
               if (phase == 2'h3)
               begin
                  state <= mmp_pkg::HST_BYTE;
                  bitn  <= 4'h0;
                  txsh  <= {tx_byte, 1'b1};
               end
            end
            mmp_pkg::HST_BYTE:
            begin
               lnk.scl <= (phase == 2'h1) | (phase == 2'h2);
               if (phase == 2'h0)
                  lnk.host_sda_oe <= ~txsh[8];
               if (phase == 2'h2)
                  rxsh <= {rxsh[7:0], in_sync[2]};
               if (phase == 2'h3)
               begin
                  txsh <= {txsh[7:0], 1'b1};
                  bitn <= bitn + 4'h1;
               end
               if (byte_end)
               begin
                  step <= step + 3'h1;
                  txsh <= (cmd_rd & (step == 3'h2)) ? 9'h1ff :
                          (step == 3'h0) ? {cmd_ofs, 1'b1} : {cmd_data, 1'b1};
                  bitn <= 4'h0;
                  if (last_rd)
                     rdata <= rxsh[8:1];
                  nack  <= ~last_rd & rxsh[0];
                  state <= (last_rd | rxsh[0] | (~cmd_rd & (step == 3'h2))) ?
                           mmp_pkg::HST_STOP :
                           (cmd_rd & (step == 3'h1)) ? mmp_pkg::HST_START :
                           mmp_pkg::HST_BYTE;
               end
            end
            mmp_pkg::HST_STOP:
            begin
               lnk.host_sda_oe <= (phase <= 2'h1);
               lnk.scl         <= (phase != 2'h0);
               if (phase == 2'h3)
                  state <= mmp_pkg::HST_IDLE;
            end
         endcase
      end

   // select and reset lines are only ever pulled low by the host
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         lnk.host_sel_oe        <= 1'b0;
         lnk.host_rst_oe        <= 1'b0;
         lnk.power_save_request <= 1'b0;
         lnk.host_sda_o         <= 1'b0;
      end
      else
      begin
         lnk.host_sel_oe        <= ctrl[`MMP_CTRL_SEL];
         lnk.host_rst_oe        <= ctrl[`MMP_CTRL_RST];
         lnk.power_save_request <= ctrl[`MMP_CTRL_LP];
         lnk.host_sda_o         <= 1'b0;
      end
endmodule  // mmp_host
`default_nettype wire

// [dv/mmp_link_asserts.sv]
// checker: assertions on the module end of the management link
`timescale 1ns/10ps
`default_nettype none
module mmp_link_asserts #(
   parameter int RESET_MIN_CYC = 8,
   parameter int INIT_CYC      = 50
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link pins
   input wire logic bus_select_n,
   input wire logic module_reset_n,
   input wire logic inserted_n,
   input wire logic mod_sda_o,
   input wire logic mod_sda_oe,
   input wire logic mod_att_o,
   input wire logic mod_att_oe
);
   logic [7:0]  low_cnt;
   logic [15:0] init_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------------------------
   // pin history
   // ---------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         low_cnt <= 8'h00;
      else if (module_reset_n)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hff)
         low_cnt <= low_cnt + 8'h01;
   // init time is tracked from power-up and after pulses long enough to count
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         init_cnt <= 16'h0001;
      else if (!module_reset_n)
         init_cnt <= 16'h0000;
      else if (low_cnt > 8'(RESET_MIN_CYC + 3))
         init_cnt <= 16'h0001;
      else if (init_cnt != 16'h0000 && init_cnt < 16'(INIT_CYC + 9))
         init_cnt <= init_cnt + 16'h0001;
      else
         init_cnt <= 16'h0000;
   sel_ignore_a: assert property (bus_select_n [*5] |-> !mod_sda_oe)
      else $error("sda driven while deselected");
   rst_quiet_a: assert property (low_cnt == 8'(RESET_MIN_CYC + 6) |-> !mod_sda_oe)
      else $error("sda driven during reset");
   rst_clear_a: assert property (low_cnt == 8'(RESET_MIN_CYC + 6) |-> !mod_att_oe)
      else $error("attention kept through reset");
   present_low_a: assert property (inserted_n == 1'b0)
      else $error("presence not shown");
   att_pull_a: assert property (mod_att_oe |-> mod_att_o == 1'b0)
      else $error("attention driven high");
   sda_pull_a: assert property (mod_sda_oe |-> !mod_sda_o)
      else $error("sda driven high");
   init_quiet_a: assert property (init_cnt != 16'h0000 && init_cnt < 16'(INIT_CYC - 2) |-> !mod_att_oe)
      else $error("attention before init end");
   init_done_a: assert property (init_cnt == 16'(INIT_CYC + 8) |-> mod_att_oe)
      else $error("no attention after init");
endmodule // mmp_link_asserts
`default_nettype wire

// [dv/module_mgmt_pins_and_access_tb_top.sv]
// testbench top: host end and module end joined over the link
`include "mmp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module module_mgmt_pins_and_access_tb_top;
   localparam int RMIN = 8;
   localparam int INIT = 50;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        fault_event = 1'b0;
   logic        power_save_active;
   logic        status_valid;
   logic [31:0] rd;
   logic        rerr;
   int          err_count = 0;
   int          compares = 0;
   mmp_if lnk_if ();
   mmp_module #(.RESET_MIN_CYC(RMIN), .INIT_CYC(INIT)) mmp_module_inst (
      .pclk(pclk), .presetn(presetn), .lnk(lnk_if), .fault_event(fault_event),
      .power_save_active(power_save_active), .status_valid(status_valid));
   mmp_host mmp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_if));
   mmp_link_asserts #(.RESET_MIN_CYC(RMIN), .INIT_CYC(INIT))
      mmp_link_asserts_inst (.pclk(pclk), .presetn(presetn),
      .bus_select_n(lnk_if.bus_select_n),
      .module_reset_n(lnk_if.module_reset_n),
      .inserted_n(lnk_if.inserted_n), .mod_sda_o(lnk_if.mod_sda_o),
      .mod_sda_oe(lnk_if.mod_sda_oe), .mod_att_o(lnk_if.mod_att_o),
      .mod_att_oe(lnk_if.mod_att_oe));
   always
      #12.5 pclk = ~pclk;
   // ---------------------------------------
   // bus tasks and scenarios
   // ---------------------------------------
   task automatic chk(input string n, input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic finish_test;
      if (err_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one serial transfer; leaves the final status word in rd
   task automatic cmd(input logic rdn, input logic [7:0] ofs, dat);
      apb(1'b1, `MMP_CMD_OFS, {15'h0000, rdn, dat, ofs});
      for (int i = 0; i < 20000; i++)
      begin
         apb(1'b0, `MMP_STAT_OFS, 32'h0000_0000);
         if (rd[0] === 1'b0)
            break;
      end
   endtask
   task automatic wait_att(input int n);
      for (int i = 0; i < n && lnk_if.attention_n !== 1'b0; i++)
         @(posedge pclk);
   endtask
   task automatic t_power_up;
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0001);
      wait_att(INIT + 20);
      chk("attention", 32'(lnk_if.attention_n), 32'h0000_0000);
      chk("valid", 32'(status_valid), 32'h0000_0001);
      apb(1'b0, `MMP_STAT_OFS, 32'h0000_0000);
      chk("seen present", 32'(rd[3:2]), 32'h0000_0003);
      cmd(1'b1, `MMP_STATUS_OFS, 8'h00);
      chk("not ready", 32'(rd[8]), 32'h0000_0000);
      chk("att release", 32'(lnk_if.attention_n), 32'h0000_0001);
   endtask
   task automatic t_page_fault;
      cmd(1'b0, `MMP_PAGE_SEL_OFS, 8'h02);
      cmd(1'b1, `MMP_PAGE_SEL_OFS, 8'h00);
      chk("page select", 32'(rd[15:8]), 32'h0000_0002);
      fault_event <= 1'b1;
      @(posedge pclk);
      fault_event <= 1'b0;
      wait_att(20);
      chk("fault att", 32'(lnk_if.attention_n), 32'h0000_0000);
      cmd(1'b1, `MMP_FLAG_OFS, 8'h00);
      chk("flag byte", 32'(rd[15:8]), 32'h0000_0002);
      chk("att clear", 32'(lnk_if.attention_n), 32'h0000_0001);
   endtask
   task automatic t_reset;
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0003);
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      chk("short pulse", 32'(status_valid), 32'h0000_0001);
      fault_event <= 1'b1;
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0003);
      fault_event <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("in reset", 32'(status_valid), 32'h0000_0000);
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0001);
      wait_att(INIT + 30);
      chk("init done", 32'(lnk_if.attention_n), 32'h0000_0000);
      cmd(1'b1, `MMP_PAGE_SEL_OFS, 8'h00);
      chk("page default", 32'(rd[15:8]), 32'h0000_0000);
   endtask
   task automatic t_select_power;
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0005);
      repeat (6) @(posedge pclk);
      chk("power save", 32'(power_save_active), 32'h0000_0001);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk("unmapped", 32'(rerr), 32'h0000_0001);
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0000);
      cmd(1'b1, `MMP_ID_OFS, 8'h00);
      chk("deselected", 32'(rd[1]), 32'h0000_0001);
      chk("power off", 32'(power_save_active), 32'h0000_0000);
      apb(1'b1, `MMP_CTRL_OFS, 32'h0000_0001);
      cmd(1'b1, `MMP_ID_OFS, 8'h00);
      chk("selected ack", 32'(rd[1]), 32'h0000_0000);
      chk("id byte", 32'(rd[15:8]), 32'h0000_005a);
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_power_up();
      t_page_fault();
      t_reset();
      t_select_power();
      finish_test();
   end
   // a stuck handshake or transfer ends the run here
   initial
   begin
      repeat (100000) @(posedge pclk);
      err_count++;
      finish_test();
   end
endmodule // module_mgmt_pins_and_access_tb_top
`default_nettype wire
